/* File: src/adwc_top.sv */
// Converter control with result formatting and programmable window detector.
// Functional notes
// [RULE1] Limits crossed: hit needs below-lt and above-gt.
// [RULE2] Otherwise hit when below-lt or above-gt.
// [RULE3] Non-matching result leaves window flag untouched.
// [RULE4] Differential results compare as signed words.
// [RULE5] Compare formatted result pair against raw limits.
// [RULE6] Conversion lasts sixteen converter clocks minimum.
// [RULE7] Converter active only while enable bit set.
// [RULE8] Less-than high byte, read/write, resets zero.
// [RULE9] Software alone clears the window flag.
// [RULE10] Greater-than bytes reset to all ones.
// [RULE11] Justification layout and sign-fill of result.
`timescale 1ns/1ps
module adwc_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Special function register port
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   // Analog side
   input  wire logic [11:0] sar_data_i,
   input  wire logic        differential_i,
   output logic             converter_power_o,
   output logic             track_hold_o,
   output logic             conversion_busy_o,
   output logic             window_hit_o
);
   logic [7:0]  converter_control_register_q;
   logic [7:0]  result_high_byte_q;
   logic [7:0]  result_low_byte_q;
   logic [7:0]  greater_than_limit_high_byte_q;
   logic [7:0]  greater_than_limit_low_byte_q;
   logic [7:0]  less_than_limit_high_byte_q;
   logic [7:0]  less_than_limit_low_byte_q;
   logic [11:0] data_meta_q;
   logic [11:0] data_sync_q;
   logic        diff_meta_q;
   logic        diff_sync_q;
   logic [5:0]  div_q;
   logic        sar_tick_q;
   logic [4:0]  conv_cnt_q;
   logic        converter_enable_bit;
   logic        left_justify_select;
   logic        conversion_busy_bit;
   logic        ctrl_wr;
   logic        start;
   logic        finish;
   logic [15:0] word_d;
   logic        hit;

   assign converter_enable_bit = converter_control_register_q[adwc_pkg::BIT_ENABLE];
   assign left_justify_select  = converter_control_register_q[adwc_pkg::BIT_LJUST];
   assign conversion_busy_bit  = converter_control_register_q[adwc_pkg::BIT_BUSY];
   assign ctrl_wr = sfr_wr_i && (sfr_addr_i == adwc_pkg::ADDR_CONTROL);
   // Writing a one to busy starts a conversion only when enabled and idle.
   assign start  = ctrl_wr && sfr_wdata_i[adwc_pkg::BIT_BUSY] && converter_enable_bit
                   && sfr_wdata_i[adwc_pkg::BIT_ENABLE] && !conversion_busy_bit; // [RULE7]
   assign finish = conversion_busy_bit && converter_enable_bit && sar_tick_q
                   && (conv_cnt_q == adwc_pkg::CONV_LAST); // [RULE6]

   // The converter output is held steady while the result is taken, so a plain
   // two-stage synchroniser per bit is safe for this multi-bit sample.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_meta_q <= 12'h000;
         data_sync_q <= 12'h000;
         diff_meta_q <= 1'b0;
         diff_sync_q <= 1'b0;
      end else begin
         data_meta_q <= sar_data_i;
         data_sync_q <= data_meta_q;
         diff_meta_q <= differential_i;
         diff_sync_q <= diff_meta_q;
      end
   end

   // Converter clock enable; it only runs while a conversion is in progress.
   // Restarting the divider at every start keeps each conversion the same
   // length, whatever phase the previous one stopped in.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_q      <= '0;
         sar_tick_q <= 1'b0;
      end else if (!conversion_busy_bit || start) begin
         div_q      <= '0;
         sar_tick_q <= 1'b0;
      end else begin
         sar_tick_q <= (div_q == adwc_pkg::DIV_LAST);
         div_q      <= (div_q == adwc_pkg::DIV_LAST) ? '0 : div_q + 6'h01;
      end
   end

   // Count converter clocks of the running conversion.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         conv_cnt_q <= '0;
      end else if (start || !conversion_busy_bit) begin
         conv_cnt_q <= '0;
      end else if (sar_tick_q) begin
         conv_cnt_q <= conv_cnt_q + 5'h01; // [RULE6]
      end
   end

   // Lay the 12-bit sample out in the 16-bit pair.
   // Single-ended samples are never sign filled, so a full-scale reading does
   // not look negative to the compare.
   always_comb begin
      if (left_justify_select) begin
         word_d = {data_sync_q, 4'h0}; // [RULE11]
      end else begin
         word_d = {{4{diff_sync_q & data_sync_q[11]}}, data_sync_q}; // [RULE11]
      end
   end

   adwc_window_cmp u_cmp (
      .result_i   (word_d),
      .lt_limit_i ({less_than_limit_high_byte_q, less_than_limit_low_byte_q}), // [RULE5]
      .gt_limit_i ({greater_than_limit_high_byte_q, greater_than_limit_low_byte_q}),
      .signed_i   (diff_sync_q),
      .hit_o      (hit)
   );

   // Result pair, loaded at end of conversion.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_high_byte_q <= adwc_pkg::RST_RESULT;
         result_low_byte_q  <= adwc_pkg::RST_RESULT;
      end else if (finish) begin
         result_high_byte_q <= word_d[15:8];
         result_low_byte_q  <= word_d[7:0];
      end
   end

   // Limit registers.
   // A limit is written a byte at a time, so software should change it only
   // while no conversion can end, or a half-written word may be compared.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         greater_than_limit_high_byte_q <= adwc_pkg::RST_GT_BYTE; // [RULE10]
         greater_than_limit_low_byte_q  <= adwc_pkg::RST_GT_BYTE; // [RULE10]
         less_than_limit_high_byte_q    <= adwc_pkg::RST_LT_BYTE; // [RULE8]
         less_than_limit_low_byte_q     <= adwc_pkg::RST_LT_BYTE;
      end else if (sfr_wr_i) begin
         case (sfr_addr_i)
            adwc_pkg::ADDR_GT_HIGH: greater_than_limit_high_byte_q <= sfr_wdata_i;
            adwc_pkg::ADDR_GT_LOW:  greater_than_limit_low_byte_q  <= sfr_wdata_i;
            adwc_pkg::ADDR_LT_HIGH: less_than_limit_high_byte_q    <= sfr_wdata_i; // [RULE8]
            adwc_pkg::ADDR_LT_LOW:  less_than_limit_low_byte_q     <= sfr_wdata_i;
            default: ;
         endcase
      end
   end

   // Control register. Hardware setting a flag wins over a software clear
   // in the same cycle, so no completed conversion is ever missed.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         converter_control_register_q <= adwc_pkg::RST_CONTROL;
      end else begin
         if (ctrl_wr) begin
            converter_control_register_q[7:5] <= sfr_wdata_i[7:5];
            converter_control_register_q[3:0] <= sfr_wdata_i[3:0]; // [RULE9]
         end
         if (start) begin
            converter_control_register_q[adwc_pkg::BIT_BUSY] <= 1'b1;
         end else if (finish || !converter_enable_bit) begin
            converter_control_register_q[adwc_pkg::BIT_BUSY] <= 1'b0; // [RULE7]
         end
         if (ctrl_wr && !sfr_wdata_i[adwc_pkg::BIT_ENABLE]) begin
            converter_control_register_q[adwc_pkg::BIT_BUSY] <= 1'b0; // [RULE7]
         end
         if (finish) begin
            converter_control_register_q[adwc_pkg::BIT_DONE] <= 1'b1;
            if (hit) begin
               converter_control_register_q[adwc_pkg::BIT_WINDOW] <= 1'b1; // [RULE1] [RULE2]
            end
            // A miss leaves the window flag alone. [RULE3]
         end
      end
   end

   // Registered read data.
   // Unmapped addresses read as zero rather than holding the last value.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sfr_rdata_o <= adwc_pkg::RST_RDATA;
      end else if (sfr_rd_i) begin
         case (sfr_addr_i)
            adwc_pkg::ADDR_CONTROL:  sfr_rdata_o <= converter_control_register_q;
            adwc_pkg::ADDR_RES_HIGH: sfr_rdata_o <= result_high_byte_q;
            adwc_pkg::ADDR_RES_LOW:  sfr_rdata_o <= result_low_byte_q;
            adwc_pkg::ADDR_GT_HIGH:  sfr_rdata_o <= greater_than_limit_high_byte_q;
            adwc_pkg::ADDR_GT_LOW:   sfr_rdata_o <= greater_than_limit_low_byte_q;
            adwc_pkg::ADDR_LT_HIGH:  sfr_rdata_o <= less_than_limit_high_byte_q; // [RULE8]
            adwc_pkg::ADDR_LT_LOW:   sfr_rdata_o <= less_than_limit_low_byte_q;
            default:                 sfr_rdata_o <= adwc_pkg::RST_RDATA;
         endcase
      end
   end

   // Analog enables and status outputs, all registered.
   // Each output lags its register bit by one clock.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         converter_power_o <= 1'b0;
         track_hold_o      <= 1'b0;
         conversion_busy_o <= 1'b0;
         window_hit_o      <= 1'b0;
      end else begin
         converter_power_o <= converter_enable_bit; // [RULE7]
         track_hold_o      <= converter_enable_bit & ~conversion_busy_bit; // [RULE7]
         conversion_busy_o <= conversion_busy_bit;
         window_hit_o      <= converter_control_register_q[adwc_pkg::BIT_WINDOW];
      end
   end
endmodule

/* File: src/adwc_pkg.sv */
// Constants shared by the window-compare converter control block.
package adwc_pkg;
   // Special function register addresses.
   localparam logic [7:0] ADDR_CONTROL  = 8'hE8;
   localparam logic [7:0] ADDR_RES_LOW  = 8'hBE;
   localparam logic [7:0] ADDR_RES_HIGH = 8'hBF;
   localparam logic [7:0] ADDR_GT_LOW   = 8'hC4;
   localparam logic [7:0] ADDR_GT_HIGH  = 8'hC5;
   localparam logic [7:0] ADDR_LT_LOW   = 8'hC6;
   localparam logic [7:0] ADDR_LT_HIGH  = 8'hC7;

   // Control register bit positions.
   localparam int BIT_ENABLE  = 7;
   localparam int BIT_DONE    = 5;
   localparam int BIT_BUSY    = 4;
   localparam int BIT_WINDOW  = 1;
   localparam int BIT_LJUST   = 0;

   // Reset values.
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_RESULT  = 8'h00;
   localparam logic [7:0] RST_GT_BYTE = 8'hFF;
   localparam logic [7:0] RST_LT_BYTE = 8'h00;
   localparam logic [7:0] RST_RDATA   = 8'h00;

   // Timing: converter clock derived from the system clock.
   localparam int SYS_CLK_HZ     = 100_000_000;
   localparam int SAR_CLK_MAX_HZ = 2_500_000;
   localparam int SAR_DIV        = (SYS_CLK_HZ + SAR_CLK_MAX_HZ - 1) / SAR_CLK_MAX_HZ;
   localparam int CONV_SAR_CLKS  = 16;
   localparam int DIV_W          = 6;
   localparam int CNT_W          = 5;
   localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(SAR_DIV - 1);
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_SAR_CLKS - 1);

   // Data widths.
   localparam int RAW_W  = 12;
   localparam int WORD_W = 16;
endpackage

/* File: src/adwc_window_cmp.sv */
// Window comparison of a formatted conversion word against the two limits.
`timescale 1ns/1ps
module adwc_window_cmp (
   // Operands
   input  wire logic [15:0] result_i,
   input  wire logic [15:0] lt_limit_i,
   input  wire logic [15:0] gt_limit_i,
   input  wire logic        signed_i,
   // Outcome
   output logic             hit_o
);
   logic below_lt;
   logic above_gt;
   logic lt_over_gt;

   function automatic logic less(input logic [15:0] a, input logic [15:0] b, input logic sgn);
      if (sgn) begin
         less = $signed(a) < $signed(b);
      end else begin
         less = a < b;
      end
   endfunction

   always_comb begin
      below_lt   = less(result_i, lt_limit_i, signed_i); // [RULE4]
      above_gt   = less(gt_limit_i, result_i, signed_i); // [RULE4]
      lt_over_gt = less(gt_limit_i, lt_limit_i, signed_i);
      if (lt_over_gt) begin
         hit_o = below_lt & above_gt; // [RULE1]
      end else begin
         hit_o = below_lt | above_gt; // [RULE2]
      end
   end
endmodule

/* File: verification/adwc_top_asserts.sv */
// Port-level checks for the window-compare converter block.
`timescale 1ns/1ps
module adwc_top_asserts (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   // Register port
   input wire logic [7:0]  sfr_addr_i,
   input wire logic        sfr_wr_i,
   input wire logic        sfr_rd_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic [7:0]  sfr_rdata_o,
   // Analog side
   input wire logic [11:0] sar_data_i,
   input wire logic        differential_i,
   input wire logic        converter_power_o,
   input wire logic        track_hold_o,
   input wire logic        conversion_busy_o,
   input wire logic        window_hit_o
);
   logic [9:0] busy_cnt_q;
   logic       ctl_wr;
   logic       lt_wr;
   logic       clr_wr;
   logic       set_wr;
   assign ctl_wr = sfr_wr_i && (sfr_addr_i == adwc_pkg::ADDR_CONTROL);
   assign lt_wr = sfr_addr_i == adwc_pkg::ADDR_LT_HIGH;
   // Software writes of the window flag reach the pin two edges after they are taken.
   assign clr_wr = ctl_wr && !sfr_wdata_i[adwc_pkg::BIT_WINDOW];
   assign set_wr = ctl_wr && sfr_wdata_i[adwc_pkg::BIT_WINDOW];
   // Counts how long the busy output has stood high.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_cnt_q <= 10'h000;
      end else begin
         busy_cnt_q <= conversion_busy_o ? busy_cnt_q + 10'h001 : 10'h000;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   property p_power_on;
      ctl_wr && sfr_wdata_i[7] ##1 !ctl_wr |-> ##1 converter_power_o;
   endproperty
   a_power_on: assert property (p_power_on) else $error("power did not follow enable");
   property p_power_off;
      ctl_wr && !sfr_wdata_i[7] ##1 !ctl_wr |-> ##1 !converter_power_o;
   endproperty
   a_power_off: assert property (p_power_off) else $error("power stayed on");
   property p_track_power;
      track_hold_o |-> converter_power_o && !conversion_busy_o;
   endproperty
   a_track_power: assert property (p_track_power) else $error("track-and-hold out of place");
   property p_busy_power;
      conversion_busy_o |-> converter_power_o;
   endproperty
   a_busy_power: assert property (p_busy_power) else $error("busy while shut down");
   property p_busy_len;
      $fell(conversion_busy_o) && converter_power_o |-> busy_cnt_q >= adwc_pkg::CONV_SAR_CLKS * adwc_pkg::SAR_DIV;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("conversion too short");
   property p_flag_fall;
      $fell(window_hit_o) |-> $past(clr_wr, 2);
   endproperty
   a_flag_fall: assert property (p_flag_fall) else $error("window flag cleared by itself");
   property p_flag_rise;
      $rose(window_hit_o) |-> $fell(conversion_busy_o) || $past(set_wr, 2);
   endproperty
   a_flag_rise: assert property (p_flag_rise) else $error("window flag set outside conversion end");
   property p_lt_back;
      sfr_wr_i && lt_wr ##1 !sfr_wr_i ##1 sfr_rd_i && lt_wr |=> sfr_rdata_o == $past(sfr_wdata_i, 3);
   endproperty
   a_lt_back: assert property (p_lt_back) else $error("limit byte readback wrong");
   c_conv: cover property ($fell(conversion_busy_o));
   c_hit: cover property ($rose(window_hit_o));
   c_clear: cover property ($fell(window_hit_o));
endmodule

/* File: verification/adwc_top_tb.sv */
// Self-checking bench for the window-compare converter block.
`timescale 1ns/1ps
module adwc_top_tb;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [7:0]  sfr_addr_i = 8'h00;
   logic        sfr_wr_i = 1'b0;
   logic        sfr_rd_i = 1'b0;
   logic [7:0]  sfr_wdata_i = 8'h00;
   logic [7:0]  sfr_rdata_o;
   logic [11:0] sar_data_i = 12'h000;
   logic        differential_i = 1'b0;
   logic        converter_power_o;
   logic        track_hold_o;
   logic        conversion_busy_o;
   logic        window_hit_o;
   int          n_fail = 0;
   int          num_checks = 0;
   // Row: sample, flags (differential, left, clear, hit), less-than, greater-than, result word.
   logic [63:0] cases [7] = '{64'h0FFB_0100_FFFF_00FF, 64'hFFEA_0100_FFFF_FFFE, 64'h101B_FFFF_0100_0101,
      64'h0009_FFFF_0100_0000, 64'hFFF6_1000_FFF0_FFF0, 64'h8003_0900_0700_0800, 64'h800B_0000_0000_F800};
   always #5 clk_i = ~clk_i;
   adwc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sar_data_i(sar_data_i),
      .differential_i(differential_i), .converter_power_o(converter_power_o), .track_hold_o(track_hold_o),
      .conversion_busy_o(conversion_busy_o), .window_hit_o(window_hit_o));
   task automatic end_of_test();
      if (n_fail == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge clk_i);
      sfr_rd_i <= 1'b0;
      #1 d = sfr_rdata_o;
   endtask
   // Polls the busy output, and gives up rather than hang if it never moves.
   task automatic wait_busy(input logic lvl, output int n);
      n = 0;
      #1;
      while (conversion_busy_o !== lvl && n < 2000) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (conversion_busy_o !== lvl) begin
         chk("busy wait", 16'(lvl), 16'(conversion_busy_o));
         end_of_test();
      end
   endtask
   initial begin
      logic [7:0]  r;
      logic [7:0]  ctl;
      logic [63:0] c;
      int          n;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(adwc_pkg::ADDR_LT_HIGH, r);
      chk("lt high reset", 16'h0000, 16'(r));
      rd(adwc_pkg::ADDR_GT_HIGH, r);
      chk("gt high reset", 16'h00FF, 16'(r));
      rd(adwc_pkg::ADDR_GT_LOW, r);
      chk("gt low reset", 16'h00FF, 16'(r));
      wr(adwc_pkg::ADDR_LT_HIGH, 8'hA5);
      rd(adwc_pkg::ADDR_LT_HIGH, r);
      chk("lt high rw", 16'h00A5, 16'(r));
      rd(8'h00, r);
      chk("unmapped", 16'h0000, 16'(r));
      chk("power at reset", 16'h0000, 16'(converter_power_o));
      for (int i = 0; i < 7; i++) begin
         c = cases[i];
         @(posedge clk_i);
         sar_data_i <= c[63:52];
         differential_i <= c[51];
         // Without the clear flag the window bit is written back as one, so it must survive.
         ctl = 8'h80 | (c[50] ? 8'h01 : 8'h00) | (c[49] ? 8'h00 : 8'h02);
         wr(adwc_pkg::ADDR_CONTROL, ctl);
         wr(adwc_pkg::ADDR_LT_HIGH, c[47:40]);
         wr(adwc_pkg::ADDR_LT_LOW, c[39:32]);
         wr(adwc_pkg::ADDR_GT_HIGH, c[31:24]);
         wr(adwc_pkg::ADDR_GT_LOW, c[23:16]);
         chk("power on", 16'h0001, 16'(converter_power_o));
         chk("track on", 16'h0001, 16'(track_hold_o));
         wr(adwc_pkg::ADDR_CONTROL, ctl | 8'h10);
         wait_busy(1'b1, n);
         chk("track in conversion", 16'h0000, 16'(track_hold_o));
         wait_busy(1'b0, n);
         chk("busy cycles", 16'h0001, 16'(n >= adwc_pkg::CONV_SAR_CLKS * adwc_pkg::SAR_DIV));
         chk("busy cycles max", 16'h0001, 16'(n <= adwc_pkg::CONV_SAR_CLKS * adwc_pkg::SAR_DIV + 2));
         chk("window pin", 16'(c[48]), 16'(window_hit_o));
         rd(adwc_pkg::ADDR_CONTROL, r);
         chk("window flag", 16'(c[48]), 16'(r[adwc_pkg::BIT_WINDOW]));
         rd(adwc_pkg::ADDR_RES_HIGH, r);
         chk("result high", 16'(c[15:8]), 16'(r));
         rd(adwc_pkg::ADDR_RES_LOW, r);
         chk("result low", 16'(c[7:0]), 16'(r));
      end
      wr(adwc_pkg::ADDR_CONTROL, 8'h00);
      rd(adwc_pkg::ADDR_CONTROL, r);
      chk("flags cleared", 16'h0000, 16'(r));
      repeat (2) @(posedge clk_i);
      #1 chk("power off", 16'h0000, 16'(converter_power_o));
      end_of_test();
   end
endmodule
bind adwc_top adwc_top_asserts u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
   .sar_data_i(sar_data_i), .differential_i(differential_i), .converter_power_o(converter_power_o),
   .track_hold_o(track_hold_o), .conversion_busy_o(conversion_busy_o), .window_hit_o(window_hit_o));
